// file: hvf_freq_meter.sv
// sync frequency meter: separation, counting, result latches, ahb-lite registers
`timescale 1ns/1ps
`default_nettype none
`include "hvf_regs.svh"
module hvf_freq_meter #(
  parameter int unsigned PRE_TMO = `HVF_PRE_TMO_CYC,
  parameter int unsigned VDIV = `HVF_VDIV
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // sync inputs and selected vertical output
  input wire logic hsync,
  input wire logic vsync,
  output logic vblank_src
);
  localparam logic [`HVF_HCNT_W-1:0] HMAX = '1;
  localparam logic [`HVF_VCNT_W-1:0] VMAX = '1;

  logic hs_f, vs_f, cvs, extracted_vsync_present;
  logic hs_q, vs_q, vsel_q, vsel, use_ext, sel_pre;
  logic hs_rise, vs_rise, vsel_rise;
  logic vpin_pre_q;
  logic [`HVF_PRE_W-1:0] vtmo_q;
  logic [7:0] ctrl_q;
  logic [7:0] rd_d;
  hvf_pkg::hvf_addr_s ap_q;
  hvf_pkg::hvf_hwin_e hst_q;
  logic [`HVF_HCNT_W-1:0] hcnt_q;
  logic [5:0] hper_q;
  logic hovf_run_q;
  logic hdiv_q;
  logic [4:0] vdiv_q;
  hvf_pkg::hvf_hres_s hmeas_q, hres_q;
  logic hmeas_new_q, hmeas_vld_q, hlatch;
  logic [`HVF_VCNT_W-1:0] vcnt_q;
  logic vovf_run_q, vrun_q;
  hvf_pkg::hvf_vres_s vres_q;
  logic hfreq_change_flag_q, vfreq_change_flag_q;
  logic flag_wr;

  // register index from a byte address; bits above the word index are ignored
  function automatic logic [7:0] hvf_idx(input logic [31:0] a);
    hvf_idx = a[9:2];
  endfunction

  // true when a word write hits the given index
  function automatic logic hvf_hit(input hvf_pkg::hvf_addr_s ap, input logic [7:0] idx);
    hvf_hit = ap.wr && (ap.idx == idx);
  endfunction

  // input noise filters
  hvf_deglitch u_hs_flt (
    .hclk(hclk),
    .hresetn(hresetn),
    .sync_in(hsync),
    .sync_out(hs_f)
  );
  hvf_deglitch u_vs_flt (
    .hclk(hclk),
    .hresetn(hresetn),
    .sync_in(vsync),
    .sync_out(vs_f)
  );

  // composite separation works on the horizontal input
  hvf_csync_sep #(
    .PRE_TMO(PRE_TMO)
  ) u_sep (
    .hclk(hclk),
    .hresetn(hresetn),
    .csync(hs_f),
    .extracted_vertical_sync(cvs),
    .extracted_vsync_present(extracted_vsync_present)
  );

  // edge history of filtered and selected syncs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hs_q <= 1'b0;
      vs_q <= 1'b0;
      vsel_q <= 1'b0;
    end else begin
      hs_q <= hs_f;
      vs_q <= vs_f;
      vsel_q <= vsel;
    end
  end
  assign hs_rise = hs_f & ~hs_q;
  assign vs_rise = vs_f & ~vs_q;
  assign vsel_rise = vsel & ~vsel_q;

  // vertical pin presence, needed for auto switching
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vtmo_q <= '0;
      vpin_pre_q <= 1'b0;
    end else if (vs_rise) begin
      vtmo_q <= '0;
      vpin_pre_q <= 1'b1;
    end else if (vtmo_q == `HVF_PRE_W'(PRE_TMO)) begin
      vpin_pre_q <= 1'b0;
    end else begin
      vtmo_q <= vtmo_q + 1'b1;
    end
  end

  // vertical source choice
  always_comb begin
    case (ctrl_q[`HVF_SRC_MSB:`HVF_SRC_LSB])
      `HVF_SRC_EXT: use_ext = 1'b1;
      `HVF_SRC_AUTO: use_ext = extracted_vsync_present & ~vpin_pre_q;
      default: use_ext = 1'b0;
    endcase
  end
  assign vsel = use_ext ? cvs : vs_f;
  assign sel_pre = use_ext ? extracted_vsync_present : vpin_pre_q;

  // selected vertical drives the blank source output
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vblank_src <= 1'b0;
    end else begin
      vblank_src <= vsel;
    end
  end

  // horizontal window of 64 periods; result is the count shifted by four
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hst_q <= hvf_pkg::HW_WAIT;
      hcnt_q <= '0;
      hper_q <= 6'h00;
      hovf_run_q <= 1'b0;
      hdiv_q <= 1'b0;
      hmeas_q <= '0;
      hmeas_new_q <= 1'b0;
      hmeas_vld_q <= 1'b0;
    end else begin
      hmeas_new_q <= 1'b0;
      case (hst_q)
        hvf_pkg::HW_WAIT: begin
          if (hs_rise) begin
            hst_q <= hvf_pkg::HW_COUNT;
            hdiv_q <= 1'b0;
            hcnt_q <= '0;
            hper_q <= 6'h00;
            hovf_run_q <= 1'b0;
          end
        end
        hvf_pkg::HW_COUNT: begin
          if (hs_rise && hper_q == `HVF_HWIN_LAST) begin
            hmeas_q <= {hovf_run_q, hcnt_q[`HVF_HCNT_W-1 -: `HVF_HRES_W]};
            hmeas_new_q <= 1'b1;
            hmeas_vld_q <= 1'b1;
            hdiv_q <= 1'b0;
            hcnt_q <= '0;
            hper_q <= 6'h00;
            hovf_run_q <= 1'b0;
          end else begin
            if (hs_rise) begin
              hper_q <= hper_q + 6'h01;
            end
            // half rate count, so the top bits give two line periods
            hdiv_q <= ~hdiv_q;
            if (hcnt_q == HMAX) begin
              hovf_run_q <= 1'b1;
            end else if (hdiv_q) begin
              hcnt_q <= hcnt_q + 1'b1;
            end
          end
        end
        default: hst_q <= hvf_pkg::HW_WAIT;
      endcase
    end
  end

  // latch per vertical period while vertical is present, else per window
  assign hlatch = hmeas_vld_q && (sel_pre ? vsel_rise : hmeas_new_q);

  // high and low halves share one register, so they move together
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hres_q <= '0;
    end else if (hlatch) begin
      hres_q <= hmeas_q;
    end
  end

  // vertical counter between selected pulses
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vcnt_q <= '0;
      vovf_run_q <= 1'b0;
      vrun_q <= 1'b0;
      vdiv_q <= 5'h00;
      vres_q <= '0;
    end else if (vsel_rise) begin
      vdiv_q <= 5'h00;
      if (vrun_q) begin
        vres_q <= {vovf_run_q, vcnt_q[`HVF_VCNT_W-1 -: `HVF_VRES_W]};
      end
      vcnt_q <= '0;
      vovf_run_q <= 1'b0;
      vrun_q <= 1'b1;
    end else if (vcnt_q == VMAX) begin
      vovf_run_q <= 1'b1;
    end else if (vdiv_q == 5'(VDIV - 1)) begin
      // prescaled count: top bits are the period in 512-clock units
      vdiv_q <= 5'h00;
      vcnt_q <= vcnt_q + 1'b1;
    end else begin
      vdiv_q <= vdiv_q + 5'h01;
    end
  end

  // change flags; an event in the clearing cycle wins over the clear
  assign flag_wr = hvf_hit(ap_q, `HVF_IDX_INTFLG);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hfreq_change_flag_q <= 1'b0;
      vfreq_change_flag_q <= 1'b0;
    end else begin
      if (hlatch && (hmeas_q.val != hres_q.val || hmeas_q.ovf)) begin
        hfreq_change_flag_q <= 1'b1;
      end else if (flag_wr && !hwdata[`HVF_HFREQ_CHANGE_FLAG_BIT]) begin
        hfreq_change_flag_q <= 1'b0;
      end
      if (vsel_rise && vrun_q && (vcnt_q[`HVF_VCNT_W-1 -: `HVF_VRES_W] != vres_q.val || vovf_run_q)) begin
        vfreq_change_flag_q <= 1'b1;
      end else if (flag_wr && !hwdata[`HVF_VFREQ_CHANGE_FLAG_BIT]) begin
        vfreq_change_flag_q <= 1'b0;
      end
    end
  end

  // control register, written in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= `HVF_CTRL_RST;
    end else if (hvf_hit(ap_q, `HVF_IDX_CTRL)) begin
      ctrl_q <= hwdata[7:0];
    end
  end

  // read mux; reads and writes at 40h reach different registers
  always_comb begin
    rd_d = 8'h00;
    case (hvf_idx(haddr))
      `HVF_IDX_STATUS: begin
        rd_d[`HVF_EXTRACTED_VSYNC_PRESENT_BIT] = extracted_vsync_present;
        rd_d[`HVF_VPRE_BIT] = sel_pre;
      end
      `HVF_IDX_HFH: rd_d = {hres_q.ovf, 4'h0, hres_q.val[10:8]};
      `HVF_IDX_HFL: rd_d = hres_q.val[7:0];
      `HVF_IDX_VFH: rd_d = {vres_q.ovf, 6'h00, vres_q.val[8]};
      `HVF_IDX_VFL: rd_d = vres_q.val[7:0];
      `HVF_IDX_INTFLG: begin
        rd_d[`HVF_HFREQ_CHANGE_FLAG_BIT] = hfreq_change_flag_q;
        rd_d[`HVF_VFREQ_CHANGE_FLAG_BIT] = vfreq_change_flag_q;
      end
      default: rd_d = 8'h00;
    endcase
  end

  // bus slave: zero wait states, always okay; unmapped reads return zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_q <= '0;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (hsel && htrans[1] && hready) begin
        ap_q.wr <= hwrite;
        ap_q.rd <= ~hwrite;
        ap_q.idx <= hvf_idx(haddr);
        hrdata <= hwrite ? 32'h0000_0000 : {24'h00_0000, rd_d};
      end else begin
        ap_q <= '0;
      end
    end
  end

  AST_DEGLITCH: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(hs_f) |-> $past(hsync, 1) && $past(hsync, 2)) else $error("short horizontal pulse passed");

  AST_SRC_EXT: assert property (@(posedge hclk) disable iff (!hresetn)
    ctrl_q[7:6] == 2'h3 |=> vblank_src == $past(cvs)) else $error("extracted source not followed");

  AST_SRC_AUTO: assert property (@(posedge hclk) disable iff (!hresetn)
    ctrl_q[7:6] == 2'h1 && !extracted_vsync_present |=> vblank_src == $past(vs_f)) else $error("auto mode left pin source");

  AST_HLATCH_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
    sel_pre && !vsel_rise |=> $stable(hres_q)) else $error("horizontal result moved mid frame");

  AST_HWIN: assert property (@(posedge hclk) disable iff (!hresetn)
    hst_q == hvf_pkg::HW_COUNT && hs_rise && hper_q == 6'h3F |=> hmeas_new_q && hcnt_q == 15'h0000)
    else $error("window of 64 periods not closed");

  AST_VSAT: assert property (@(posedge hclk) disable iff (!hresetn)
    vcnt_q == VMAX && !vsel_rise |=> vcnt_q == VMAX && vovf_run_q) else $error("vertical counter wrapped");

  AST_VLATCH: assert property (@(posedge hclk) disable iff (!hresetn)
    vsel_rise && vrun_q |=> vres_q.val == $past(vcnt_q[13:5])) else $error("vertical result not latched");

  AST_HFREQ_CHANGE_FLAG: assert property (@(posedge hclk) disable iff (!hresetn)
    hlatch && hmeas_q.val != hres_q.val |=> hfreq_change_flag_q [*2]) else $error("horizontal change flag missing");

  AST_OVF_CLR: assert property (@(posedge hclk) disable iff (!hresetn)
    vsel_rise && vrun_q && !vovf_run_q |=> !vres_q.ovf) else $error("vertical overflow did not clear");

  AST_HFH_LAYOUT: assert property (@(posedge hclk) disable iff (!hresetn)
    hsel && htrans[1] && hready && !hwrite && haddr[9:2] == 8'h41
    |=> hrdata[7] == $past(hres_q.ovf) && hrdata[2:0] == $past(hres_q.val[10:8]))
    else $error("horizontal high register layout wrong");
endmodule
`default_nettype wire

// file: hvf_regs.svh
// register map, field positions and timing constants of the sync frequency meter
`ifndef HVF_REGS_SVH
`define HVF_REGS_SVH
// register indices; byte address is four times the index
`define HVF_IDX_STATUS 8'h40
`define HVF_IDX_HFH 8'h41
`define HVF_IDX_HFL 8'h42
`define HVF_IDX_VFH 8'h43
`define HVF_IDX_VFL 8'h44
`define HVF_IDX_CTRL 8'h40
`define HVF_IDX_INTFLG 8'h50
// field positions
`define HVF_EXTRACTED_VSYNC_PRESENT_BIT 7
`define HVF_VPRE_BIT 2
`define HVF_OVF_BIT 7
`define HVF_SRC_MSB 7
`define HVF_SRC_LSB 6
`define HVF_HFREQ_CHANGE_FLAG_BIT 3
`define HVF_VFREQ_CHANGE_FLAG_BIT 2
// source select codes
`define HVF_SRC_EXT 2'h3
`define HVF_SRC_PIN 2'h2
`define HVF_SRC_OFF 2'h0
`define HVF_SRC_AUTO 2'h1
// reset values
`define HVF_CTRL_RST 8'h00
`define HVF_FLAG_RST 8'h00
// widths and window
`define HVF_HCNT_W 15
`define HVF_VCNT_W 14
`define HVF_HRES_W 11
`define HVF_VRES_W 9
`define HVF_HWIN_LAST 6'h3F
// vertical counter prescale, clocks per count
`define HVF_VDIV 16
// timing: clock rate, separation delay, presence timeout
`define HVF_CLK_MHZ 100
`define HVF_CV_DLY_NS 12000
`define HVF_CV_DLY_CYC (`HVF_CV_DLY_NS * `HVF_CLK_MHZ / 1000)
`define HVF_PRE_TMO_US 50000
`define HVF_PRE_TMO_CYC (`HVF_PRE_TMO_US * `HVF_CLK_MHZ)
`define HVF_PRE_W 23
`endif

// file: hvf_pkg.sv
// shared types of the sync frequency meter
package hvf_pkg;
  // captured bus address phase
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] idx;
  } hvf_addr_s;
  // latched horizontal result, overflow with value
  typedef struct packed {
    logic ovf;
    logic [10:0] val;
  } hvf_hres_s;
  // latched vertical result
  typedef struct packed {
    logic ovf;
    logic [8:0] val;
  } hvf_vres_s;
  // horizontal window sequencing
  typedef enum logic [0:0] {HW_WAIT, HW_COUNT} hvf_hwin_e;
endpackage

// file: hvf_deglitch.sv
// noise filter dropping sync pulses sampled on only one clock edge
`timescale 1ns/1ps
`default_nettype none
module hvf_deglitch (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // raw and filtered sync
  input wire logic sync_in,
  output var logic sync_out
);
  logic prev_q;

  // previous sample
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= sync_in;
    end
  end

  // a level counts only once seen on two edges in a row
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync_out <= 1'b0;
    end else if (sync_in == prev_q) begin
      sync_out <= prev_q;
    end
  end
endmodule
`default_nettype wire

// file: hvf_csync_sep.sv
// vertical sync extraction from composite horizontal sync
`timescale 1ns/1ps
`default_nettype none
`include "hvf_regs.svh"
module hvf_csync_sep #(
  parameter int unsigned PRE_TMO = `HVF_PRE_TMO_CYC
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // filtered composite sync
  input wire logic csync,
  // extracted sync and its presence
  output var logic extracted_vertical_sync,
  output var logic extracted_vsync_present
);
  localparam logic [10:0] DLY = 11'(`HVF_CV_DLY_CYC);
  logic prev_q;
  logic [10:0] run_q;
  logic [10:0] hi_len_q;
  logic [10:0] lo_len_q;
  logic act_hi_q;
  logic [`HVF_PRE_W-1:0] tmo_q;
  logic [10:0] tail_q;
  logic edge_w;

  assign edge_w = csync ^ prev_q;

  // run length of the present level, saturating
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_q <= 1'b0;
      run_q <= 11'h000;
    end else begin
      prev_q <= csync;
      if (edge_w) begin
        run_q <= 11'h000;
      end else if (run_q != 11'h7FF) begin
        run_q <= run_q + 11'h001;
      end
    end
  end

  // the shorter level is the active pulse level; long pulses left out so polarity holds
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hi_len_q <= 11'h000;
      lo_len_q <= 11'h000;
      act_hi_q <= 1'b0;
    end else if (edge_w && run_q < DLY) begin
      if (prev_q) begin
        hi_len_q <= run_q;
      end else begin
        lo_len_q <= run_q;
      end
      act_hi_q <= hi_len_q < lo_len_q;
    end
  end

  // a long active run marks the vertical pulse; its end is delayed by the same lag
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      extracted_vertical_sync <= 1'b0;
      tail_q <= 11'h000;
    end else if (!edge_w && run_q == DLY && csync == act_hi_q) begin
      extracted_vertical_sync <= 1'b1;
      tail_q <= 11'h000;
    end else if (edge_w && prev_q == act_hi_q && run_q >= DLY) begin
      tail_q <= DLY;
    end else if (tail_q == 11'h001) begin
      extracted_vertical_sync <= 1'b0;
      tail_q <= 11'h000;
    end else if (tail_q != 11'h000) begin
      tail_q <= tail_q - 11'h001;
    end
  end

  // present while extracted pulses keep coming
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tmo_q <= '0;
      extracted_vsync_present <= 1'b0;
    end else if (run_q == DLY && csync == act_hi_q && !extracted_vertical_sync) begin
      tmo_q <= '0;
      extracted_vsync_present <= 1'b1;
    end else if (tmo_q == `HVF_PRE_W'(PRE_TMO)) begin
      extracted_vsync_present <= 1'b0;
    end else begin
      tmo_q <= tmo_q + 1'b1;
    end
  end
endmodule
`default_nettype wire

// file: hvf_video_src.sv
// video source model driving line, composite and frame sync into the meter
`timescale 1ns/1ps
`default_nettype none
module hvf_video_src (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // line and frame periods in clocks
  input wire logic [9:0] hper,
  input wire logic [15:0] vper,
  // mode controls
  input wire logic vpin_en,
  input wire logic comp_en,
  input wire logic glitch_en,
  // sync outputs and frame start marker
  output logic hsync,
  output logic vsync,
  output logic vstart
);
  logic [9:0] hc_q;
  logic [15:0] vc_q;
  // line counter; wraps on >= so a shortened period never runs away
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hc_q <= 10'h000;
    end else if (hc_q >= hper - 10'h001) begin
      hc_q <= 10'h000;
    end else begin
      hc_q <= hc_q + 10'h001;
    end
  end
  // frame counter, same wrap rule as the line counter
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vc_q <= 16'h0000;
    end else if (vc_q >= vper - 16'h0001) begin
      vc_q <= 16'h0000;
    end else begin
      vc_q <= vc_q + 16'h0001;
    end
  end
  // composite mode holds line sync active through a 20 us frame pulse
  assign hsync = (comp_en && (vc_q < 16'h07D0)) ? 1'b1 : (hc_q < 10'h008);
  // one-clock spike mid-frame, must be dropped as noise
  assign vsync = vpin_en & ((vc_q < 16'h0010) | (glitch_en & (vc_q == (vper >> 1))));
  // marks the start of the composite frame pulse
  assign vstart = comp_en & (vc_q == 16'h0000);
endmodule
`default_nettype wire

// file: test_hv_sync_frequency_meter.sv
// self-checking bench of the sync frequency meter
`timescale 1ns/1ps
`default_nettype none
`include "hvf_regs.svh"
module test_hv_sync_frequency_meter;
  localparam int CEIL = 105000;
  localparam logic [31:0] A_STAT = {22'h0, `HVF_IDX_STATUS, 2'h0};
  localparam logic [31:0] A_HFH = {22'h0, `HVF_IDX_HFH, 2'h0};
  localparam logic [31:0] A_HFL = {22'h0, `HVF_IDX_HFL, 2'h0};
  localparam logic [31:0] A_VFH = {22'h0, `HVF_IDX_VFH, 2'h0};
  localparam logic [31:0] A_VFL = {22'h0, `HVF_IDX_VFL, 2'h0};
  localparam logic [31:0] A_FLG = {22'h0, `HVF_IDX_INTFLG, 2'h0};
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [9:0] hper = 10'h064;
  logic [15:0] vper = 16'h1400;
  logic vpin_en = 1'b1;
  logic comp_en = 1'b0;
  logic glitch_en = 1'b1;
  wire logic [31:0] hrdata;
  wire logic hreadyout;
  wire logic hresp;
  wire logic hsync;
  wire logic vsync;
  wire logic vstart;
  wire logic vblank_src;
  int err_total = 0;
  int checks = 0;
  int cyc = 0;
  // 100 MHz clock
  always #5 hclk = ~hclk;
  // vertical prescale of one keeps the overflow frame inside the run length
  hvf_freq_meter #(.PRE_TMO(2000), .VDIV(1)) dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .hsync(hsync), .vsync(vsync), .vblank_src(vblank_src)
  );
  hvf_video_src src_u (
    .hclk(hclk), .hresetn(hresetn), .hper(hper), .vper(vper), .vpin_en(vpin_en),
    .comp_en(comp_en), .glitch_en(glitch_en), .hsync(hsync), .vsync(vsync), .vstart(vstart)
  );
  // verdict and end of run
  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // hang guard
  always @(posedge hclk) begin
    cyc++;
    if (cyc == CEIL) begin
      err_total++;
      report_and_stop();
    end
  end
  // range compare; unknown bits never pass
  task automatic chk(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    checks++;
    if (((got >= lo) && (got <= hi)) !== 1'b1) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask
  task automatic wcyc(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // one ahb-lite single transfer, entered just after a rising edge
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rdat);
    int n;
    n = 0;
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      @(posedge hclk);
      n++;
    end
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      @(posedge hclk);
      n++;
    end
    rdat = hrdata;
  endtask
  task automatic rdr(input logic [31:0] a, output logic [31:0] d);
    bus(1'b0, a, 32'h0, d);
  endtask
  task automatic wrr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    bus(1'b1, a, d, dummy);
  endtask
  // results and flags are empty after reset, unmapped reads give zero
  task automatic t_reset();
    logic [31:0] d;
    logic [31:0] addrs [6];
    addrs = '{A_HFH, A_HFL, A_VFH, A_VFL, A_FLG, 32'h0000_01FC};
    foreach (addrs[i]) begin
      rdr(addrs[i], d);
      chk(d, 32'h0, 32'h0);
    end
    chk({31'h0, hresp}, 32'h0, 32'h0);
    $display("test reset done");
  endtask
  // pin source, 100-clock lines, 5120-clock frames with a noise spike
  task automatic t_meas();
    logic [31:0] hh, hl, vh, vl, fl;
    wrr(A_STAT, 32'h0000_0080);
    wcyc(15360);
    rdr(A_HFH, hh);
    rdr(A_HFL, hl);
    chk({21'h0, hh[2:0], hl[7:0]}, 32'd199, 32'd201);
    chk({31'h0, hh[7]}, 32'h0, 32'h0);
    rdr(A_VFH, vh);
    rdr(A_VFL, vl);
    chk({23'h0, vh[0], vl[7:0]}, 32'd159, 32'd161);
    rdr(A_FLG, fl);
    chk(fl & 32'h0C, 32'h0C, 32'h0C);
    wrr(A_FLG, 32'h0);
    wcyc(5320);
    rdr(A_FLG, fl);
    chk(fl & 32'h0C, 32'h0, 32'h0);
    $display("test measure done");
  endtask
  // frame longer than the 14-bit count, then back to normal
  task automatic t_vovf();
    logic [31:0] vh, vl, fl;
    vper <= 16'd17000;
    wcyc(34200);
    rdr(A_VFH, vh);
    chk({31'h0, vh[7]}, 32'h1, 32'h1);
    rdr(A_FLG, fl);
    chk(fl & 32'h04, 32'h04, 32'h04);
    vper <= 16'd5120;
    wcyc(10440);
    rdr(A_VFH, vh);
    rdr(A_VFL, vl);
    chk({31'h0, vh[7]}, 32'h0, 32'h0);
    chk({23'h0, vh[0], vl[7:0]}, 32'd159, 32'd161);
    $display("test overflow done");
  endtask
  // composite sync only; each source select code with its expected lag
  task automatic t_ext();
    logic [31:0] st;
    logic [1:0] modes [4];
    int n;
    modes = '{2'h3, 2'h1, 2'h2, 2'h0};
    comp_en <= 1'b1;
    vpin_en <= 1'b0;
    glitch_en <= 1'b0;
    foreach (modes[i]) begin
      wrr(A_STAT, {24'h0, modes[i], 6'h0});
      n = 0;
      while (vstart !== 1'b1 && n < 6000) begin
        @(posedge hclk);
        n++;
      end
      n = 0;
      while (vblank_src !== 1'b1 && n < 2000) begin
        @(posedge hclk);
        n++;
      end
      // extracted and auto follow the separated pulse, pin and off stay idle
      if (modes[i][0]) begin
        chk(n, 32'd1000, 32'd1610);
        rdr(A_STAT, st);
        chk({31'h0, st[7]}, 32'h1, 32'h1);
      end else begin
        chk(n, 32'd2000, 32'd2000);
      end
    end
    $display("test extract done");
  endtask
  // reset held for 20 cycles, then the scenarios
  initial begin
    wcyc(20);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_meas();
    t_vovf();
    t_ext();
    report_and_stop();
  end
endmodule
`default_nettype wire
